/* transfer_pkg.sv */
// Shared constants for the data transfer controller and its data buffer
package transfer_pkg;
   // ------------------------------------------------------------
   // Register offsets (byte addresses on the register port)
   // ------------------------------------------------------------
   localparam logic [7:0] CBR_OFS = 8'h00;      // Control base register
   localparam logic [7:0] GATE_OFS = 8'h04;     // Clock gate register
   localparam logic [7:0] STAT_OFS = 8'h08;     // Status register
   // ------------------------------------------------------------
   // Reset values and status field positions
   // ------------------------------------------------------------
   localparam logic [7:0] CBR_RST = 8'hFD;      // Region base after reset
   localparam logic GATE_RST = 1'b0;            // Controller gated off
   localparam int STAT_BUSY = 0;                // Transfer in flight
   localparam int STAT_DERR = 1;                // Sticky bad-area flag
   localparam int STAT_WAKE = 2;                // Wake request level
   // ------------------------------------------------------------
   // Control region layout, in bytes from the region start
   // ------------------------------------------------------------
   localparam int VEC_BYTES = 46;               // Vector table
   localparam int GAP_BYTES = 18;               // Reserved gap
   localparam int CTL_BYTES = 192;              // Control-data area
   localparam int SET_BYTES = 8;                // One control-data set
   localparam int NUM_SETS = CTL_BYTES / SET_BYTES;
   localparam logic [7:0] CTL_AREA = 8'(VEC_BYTES + GAP_BYTES);
   localparam logic [7:0] OFS_WORD0 = 8'h00;    // Control byte, count
   localparam logic [7:0] OFS_WORD1 = 8'h02;    // Reload, spare
   localparam logic [7:0] OFS_SRC = 8'h04;      // Source address
   localparam logic [7:0] OFS_DST = 8'h06;      // Destination address
   // ------------------------------------------------------------
   // Control byte field positions
   // ------------------------------------------------------------
   localparam int CB_MODE = 0;                  // 1 = repeat
   localparam int CB_SIZE = 1;                  // 1 = 16-bit unit
   localparam int CB_SINC = 2;                  // Source increment
   localparam int CB_DINC = 3;                  // Destination increment
   localparam int CB_RSEL = 4;                  // 1 = source is repeat area
   localparam int CB_FAST = 5;                  // High-speed transfer
   // ------------------------------------------------------------
   // Address map
   // ------------------------------------------------------------
   localparam logic [19:0] DATA_BASE = 20'hF0000;
   localparam logic [3:0] TOP_SEG = 4'hF;
   localparam logic [19:0] SFR_LO = 20'hFFF00;
   localparam logic [19:0] SFR2_HI = 20'hF07FF;
   localparam logic [19:0] FLASH_LO = 20'hF1000;
   localparam logic [19:0] FLASH_HI = 20'hF1FFF;
   localparam logic [19:0] MIRROR_LO = 20'hF2000;
   localparam logic [19:0] RAM_LO_DEF = 20'hFE000;
   // ------------------------------------------------------------
   // Cycle budgets per transfer and data buffer depth
   // ------------------------------------------------------------
   localparam int MAX_NORMAL_CLK = 14;
   localparam int MAX_FAST_CLK = 5;
   localparam int BUF_DEPTH = 32;
endpackage

/* unit_fifo.sv */
// Synchronous FIFO carrying transfer units from the read side to the write side
`timescale 1ns/1ps
module unit_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];       // Storage array
   logic [AW-1:0] wr_ptr_ff;            // Next slot to fill
   logic [AW-1:0] rd_ptr_ff;            // Oldest slot
   logic [AW:0] fill_ff;                // Words held
   logic push;
   logic pop;

   assign in_ready = (fill_ff != (AW+1)'(DEPTH));
   assign out_valid = (fill_ff != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr_ff];

   // ------------------------------------------------------------
   // Storage, no reset needed on data
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr_ff] <= in_data;
      end
   end

   // Pointers and fill level
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         fill_ff <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
         end
         fill_ff <= fill_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   a_fifo_no_over: assert property (@(posedge clock) disable iff (!arst_n)
      fill_ff <= (AW+1)'(DEPTH)) else $error("fifo overfilled");
endmodule

/* data_transfer_controller.sv */
// Event-driven data transfer controller with control region in RAM
`timescale 1ns/1ps
module data_transfer_controller
   import transfer_pkg::*;
#(
   parameter int NSRC = transfer_pkg::VEC_BYTES,
   parameter logic [19:0] RAM_LO = transfer_pkg::RAM_LO_DEF
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [NSRC-1:0] act_req,
   input wire logic stop_mode,
   input wire logic wake_ack,
   output logic wake_req,
   output logic [19:0] mem_addr,
   output logic mem_rd,
   output logic mem_wr,
   output logic mem_word,
   output logic [15:0] mem_wdata,
   input wire logic [15:0] mem_rdata
);
   import transfer_pkg::*;

   typedef enum {IDLE, VEC, CTL0, CTL1, CTL2, CTL3, DRD, DCAP, DWR, WB0, WB1, WB2} state_e;
   localparam int IW = $clog2(NSRC);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Destination may only be an SFR area or RAM
   function automatic logic dst_ok(input logic [19:0] a);
      dst_ok = (a >= SFR_LO) || (a <= SFR2_HI) || (a >= RAM_LO);
   endfunction
   // Sources add data flash and the mirror area
   function automatic logic src_ok(input logic [19:0] a);
      src_ok = dst_ok(a) || ((a >= FLASH_LO) && (a <= FLASH_HI)) || (a >= MIRROR_LO);
   endfunction
   // Lowest pending source wins
   function automatic logic [IW-1:0] pick(input logic [NSRC-1:0] p);
      pick = '0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (p[i]) begin
            pick = IW'(i);
         end
      end
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   state_e state_ff;                    // Sequencer
   logic [7:0] cbr_ff;                  // Control base register
   logic gate_ff;                       // Clock gate bit
   logic derr_ff;                       // Sticky bad-area flag
   logic [NSRC-1:0] pending_ff;         // Latched requests
   logic [IW-1:0] idx_ff;               // Source being served
   logic [7:0] set_ff;                  // Control set start offset
   logic [7:0] ctl_ff;                  // Control byte
   logic [7:0] cnt_ff;                  // Transfer count
   logic [7:0] rld_ff;                  // Count reload
   logic [15:0] sar_ff;                 // Source address register
   logic [15:0] dar_ff;                 // Destination address register
   logic fast_ff;                       // Current transfer is high-speed
   logic cache_ok_ff;                   // Cached set valid
   logic [IW-1:0] cache_idx_ff;         // Source owning cached set
   logic [31:0] rdata_ff;               // Register read data
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [15:0] fifo_out;
   logic push;
   logic pop;
   logic start;
   logic hit;
   logic [19:0] region;
   logic [19:0] src_addr;
   logic [19:0] dst_addr;
   logic [15:0] unit;
   logic [15:0] nxt_sar;
   logic [15:0] nxt_dar;
   logic [7:0] nxt_cnt;
   logic wrap;

   assign region = {TOP_SEG, cbr_ff, 8'h00};
   assign src_addr = DATA_BASE + {4'h0, sar_ff};
   assign dst_addr = DATA_BASE + {4'h0, dar_ff};
   assign start = gate_ff && (state_ff == IDLE) && (pending_ff != '0)
                  && (!stop_mode || wake_ack);
   assign hit = cache_ok_ff && (cache_idx_ff == pick(pending_ff));
   assign wake_req = stop_mode && gate_ff && (pending_ff != '0);
   assign push = (state_ff == DCAP) && gate_ff;
   assign pop = (state_ff == DWR) && fifo_out_valid;
   assign reg_rdata = rdata_ff;

   // ------------------------------------------------------------
   // Address and count updates
   // ------------------------------------------------------------
   always_comb begin
      unit = ctl_ff[CB_SIZE] ? 16'h0002 : 16'h0001;
      nxt_cnt = cnt_ff - 8'h01;
      wrap = ctl_ff[CB_MODE] && (nxt_cnt == 8'h00);
      nxt_sar = sar_ff;
      nxt_dar = dar_ff;
      if (ctl_ff[CB_MODE] && ctl_ff[CB_RSEL]) begin
         // Source is the repeat area, rewinds on wrap
         nxt_sar = wrap ? sar_ff + unit - 16'(rld_ff) * unit : sar_ff + unit;
         nxt_dar = ctl_ff[CB_DINC] ? dar_ff + unit : dar_ff;
      end else if (ctl_ff[CB_MODE]) begin
         nxt_dar = wrap ? dar_ff + unit - 16'(rld_ff) * unit : dar_ff + unit;
         nxt_sar = ctl_ff[CB_SINC] ? sar_ff + unit : sar_ff;
      end else begin
         nxt_sar = ctl_ff[CB_SINC] ? sar_ff + unit : sar_ff;
         nxt_dar = ctl_ff[CB_DINC] ? dar_ff + unit : dar_ff;
      end
      if (wrap) begin
         nxt_cnt = rld_ff;
      end
   end

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= IDLE;
      end else if (!gate_ff) begin
         state_ff <= IDLE;
      end else begin
         unique case (state_ff)
            IDLE: begin
               // Cached high-speed set skips the control reads
               if (start) begin
                  state_ff <= hit ? DRD : VEC;
               end
            end
            VEC: state_ff <= CTL0;
            CTL0: state_ff <= CTL1;
            CTL1: state_ff <= CTL2;
            CTL2: state_ff <= CTL3;
            CTL3: state_ff <= DRD;
            DRD: begin
               // Bad areas abort before any data moves
               if (!dst_ok(dst_addr) || !src_ok(src_addr)) begin
                  state_ff <= IDLE;
               end else if (fifo_in_ready) begin
                  state_ff <= DCAP;
               end
            end
            DCAP: state_ff <= DWR;
            DWR: begin
               if (fifo_out_valid) begin
                  state_ff <= WB0;
               end
            end
            WB0: state_ff <= fast_ff ? IDLE : WB1;
            WB1: state_ff <= WB2;
            WB2: state_ff <= IDLE;
         endcase
      end
   end

   // Pending requests: a new request beats the clear of its bit
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pending_ff <= '0;
      end else if (!gate_ff) begin
         pending_ff <= '0;
      end else begin
         pending_ff <= (pending_ff & ~((start ? NSRC'(1) : '0) << pick(pending_ff)))
                       | act_req;
      end
   end

   // ------------------------------------------------------------
   // Control data capture and update
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         idx_ff <= '0;
         set_ff <= CTL_AREA;
         ctl_ff <= 8'h00;
         cnt_ff <= 8'h00;
         rld_ff <= 8'h00;
         sar_ff <= 16'h0000;
         dar_ff <= 16'h0000;
         fast_ff <= 1'b0;
      end else begin
         unique case (state_ff)
            IDLE: begin
               if (start) begin
                  idx_ff <= pick(pending_ff);
                  fast_ff <= hit;
               end
            end
            VEC: set_ff <= mem_rdata[7:0];
            CTL0: begin
               ctl_ff <= mem_rdata[7:0];
               cnt_ff <= mem_rdata[15:8];
            end
            CTL1: rld_ff <= mem_rdata[7:0];
            CTL2: sar_ff <= mem_rdata;
            CTL3: dar_ff <= mem_rdata;
            DWR: begin
               if (fifo_out_valid) begin
                  cnt_ff <= nxt_cnt;
                  sar_ff <= nxt_sar;
                  dar_ff <= nxt_dar;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // High-speed cache of one control set; any full start drops it, as a refused set
   // would otherwise leave foreign addresses behind a still-valid cache entry
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cache_ok_ff <= 1'b0;
         cache_idx_ff <= '0;
      end else if (!gate_ff || state_ff == VEC || (reg_wr && reg_addr == CBR_OFS)) begin
         cache_ok_ff <= 1'b0;
      end else if (state_ff == WB2) begin
         cache_ok_ff <= ctl_ff[CB_FAST];
         cache_idx_ff <= idx_ff;
      end
   end

   // ------------------------------------------------------------
   // Memory port, one access per cycle
   // ------------------------------------------------------------
   always_comb begin
      mem_addr = 20'h00000;
      mem_rd = 1'b0;
      mem_wr = 1'b0;
      mem_word = 1'b1;
      mem_wdata = 16'h0000;
      unique case (state_ff)
         IDLE: begin
            mem_rd = start && !hit;
            mem_addr = region + 20'(pick(pending_ff));
            mem_word = 1'b0;
         end
         VEC: begin
            mem_rd = 1'b1;
            mem_addr = region + {12'h000, mem_rdata[7:0]} + 20'(OFS_WORD0);
         end
         CTL0: begin
            mem_rd = 1'b1;
            mem_addr = region + {12'h000, set_ff} + 20'(OFS_WORD1);
         end
         CTL1: begin
            mem_rd = 1'b1;
            mem_addr = region + {12'h000, set_ff} + 20'(OFS_SRC);
         end
         CTL2: begin
            mem_rd = 1'b1;
            mem_addr = region + {12'h000, set_ff} + 20'(OFS_DST);
         end
         DRD: begin
            mem_rd = fifo_in_ready && dst_ok(dst_addr) && src_ok(src_addr);
            mem_addr = src_addr;
            mem_word = ctl_ff[CB_SIZE];
         end
         DWR: begin
            mem_wr = fifo_out_valid;
            mem_addr = dst_addr;
            mem_word = ctl_ff[CB_SIZE];
            mem_wdata = fifo_out;
         end
         WB0: begin
            mem_wr = 1'b1;
            mem_addr = region + {12'h000, set_ff} + 20'(OFS_WORD0);
            mem_wdata = {cnt_ff, ctl_ff};
         end
         WB1: begin
            mem_wr = 1'b1;
            mem_addr = region + {12'h000, set_ff} + 20'(OFS_SRC);
            mem_wdata = sar_ff;
         end
         WB2: begin
            mem_wr = 1'b1;
            mem_addr = region + {12'h000, set_ff} + 20'(OFS_DST);
            mem_wdata = dar_ff;
         end
         default: begin
         end
      endcase
   end

   // Data buffer between read and write halves
   unit_fifo #(.WIDTH(16), .DEPTH(BUF_DEPTH)) u_buf (
      .clock(clock),
      .arst_n(arst_n),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data(mem_rdata),
      .out_valid(fifo_out_valid),
      .out_ready(pop),
      .out_data(fifo_out)
   );

   // ------------------------------------------------------------
   // Register port
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cbr_ff <= CBR_RST;
         gate_ff <= GATE_RST;
      end else if (reg_wr) begin
         // Base only moves while gated on
         if (reg_addr == CBR_OFS && gate_ff) begin
            cbr_ff <= reg_wdata[7:0];
         end
         if (reg_addr == GATE_OFS) begin
            gate_ff <= reg_wdata[0];
         end
      end
   end

   // Bad-area flag: a new error beats a software clear
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         derr_ff <= 1'b0;
      end else if (state_ff == DRD && (!dst_ok(dst_addr) || !src_ok(src_addr))) begin
         derr_ff <= 1'b1;
      end else if (reg_wr && reg_addr == STAT_OFS && reg_wdata[STAT_DERR]) begin
         derr_ff <= 1'b0;
      end
   end

   // Read data valid the cycle after the strobe only
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rdata_ff <= 32'h00000000;
      end else begin
         rdata_ff <= 32'h00000000;
         if (reg_rd) begin
            unique case (reg_addr)
               CBR_OFS: rdata_ff <= {24'h000000, cbr_ff};
               GATE_OFS: rdata_ff <= {31'h00000000, gate_ff};
               STAT_OFS: rdata_ff <= {29'h00000000, wake_req, derr_ff, state_ff != IDLE};
               default: rdata_ff <= 32'h00000000;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   int unsigned busy_cnt;               // Cycles since a transfer began
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         busy_cnt <= 0;
      end else begin
         busy_cnt <= (state_ff == IDLE) ? 0 : busy_cnt + 1;
      end
   end

   sequence s_normal_start;
      start && !hit;
   endsequence
   sequence s_ctl_reads;
      (state_ff == VEC) ##1 (state_ff == CTL0) ##1 (state_ff == CTL1) ##3 (state_ff == DRD);
   endsequence

   a_normal_steps: assert property (@(posedge clock) disable iff (!arst_n)
      s_normal_start |=> s_ctl_reads) else $error("control reads out of order");
   a_normal_len: assert property (@(posedge clock) disable iff (!arst_n)
      !fast_ff |-> busy_cnt < MAX_NORMAL_CLK) else $error("normal transfer too long");
   a_fast_len: assert property (@(posedge clock) disable iff (!arst_n)
      fast_ff |-> busy_cnt < MAX_FAST_CLK) else $error("fast transfer too long");
   a_dest_area: assert property (@(posedge clock) disable iff (!arst_n)
      (state_ff == DWR && mem_wr) |-> dst_ok(mem_addr)) else $error("bad destination");
   a_data_base: assert property (@(posedge clock) disable iff (!arst_n)
      (state_ff == DRD && mem_rd) |-> mem_addr == DATA_BASE + {4'h0, sar_ff})
      else $error("bad source address");
   a_vec_region: assert property (@(posedge clock) disable iff (!arst_n)
      s_normal_start |-> mem_addr[19:8] == {TOP_SEG, cbr_ff} && mem_addr[7:0] < 8'(VEC_BYTES))
      else $error("vector outside table");
   a_pend_hold: assert property (@(posedge clock) disable iff (!arst_n)
      (act_req != '0 && state_ff != IDLE && gate_ff) |=> (pending_ff & $past(act_req)) == $past(act_req))
      else $error("request lost while busy");
   a_count_step: assert property (@(posedge clock) disable iff (!arst_n)
      (pop && !ctl_ff[CB_MODE] && gate_ff) |=> cnt_ff == $past(cnt_ff) - 8'h01)
      else $error("count not decremented");
   a_repeat_reload: assert property (@(posedge clock) disable iff (!arst_n)
      (pop && ctl_ff[CB_MODE] && cnt_ff == 8'h01 && gate_ff) |=> cnt_ff == $past(rld_ff))
      else $error("count not reloaded");
endmodule

/* mem_model.sv */
// Behavioural memory at the far side of the transfer controller
`timescale 1ns/1ps
module mem_model (
   input wire logic clock,
   input wire logic [19:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic mem_word,
   input wire logic [15:0] mem_wdata,
   output logic [15:0] mem_rdata
);
   logic [7:0] mem [0:1048575]; // Flat byte store
   logic [15:0] rdata_ff; // Read data, one cycle after the strobe
   // ----------------------------------------
   // Access port
   // ----------------------------------------
   // Idle cycles show inverted data so a late capture cannot pass by luck
   // Plain always: the bench preloads this store through a hierarchical path
   always @(posedge clock) begin
      if (mem_wr) begin
         mem[mem_addr] <= mem_wdata[7:0];
         if (mem_word) begin
            mem[mem_addr + 20'h1] <= mem_wdata[15:8];
         end
      end
      if (mem_rd) begin
         rdata_ff <= {mem[mem_addr + 20'h1], mem[mem_addr]};
      end else begin
         rdata_ff <= ~rdata_ff;
      end
   end
   assign mem_rdata = rdata_ff;
endmodule

/* data_transfer_controller_tb.sv */
// Self-checking bench for the data transfer controller
`timescale 1ns/1ps
module data_transfer_controller_tb;
   import transfer_pkg::*;
   logic clock = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, mem_rd, mem_wr, mem_word, wake_req;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic [45:0] act_req = 46'h0;
   logic stop_mode = 0, wake_ack = 0;
   logic [19:0] mem_addr;
   logic [15:0] mem_wdata, mem_rdata;
   int err_count = 0, compares = 0;
   logic [39:0] rows [4] = '{40'h00000000FD, 40'h0400000000, 40'h0800000000, 40'h0C00000000};
   always #2 clock = ~clock; // 250 MHz
   data_transfer_controller i_dut (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .act_req(act_req), .stop_mode(stop_mode), .wake_ack(wake_ack), .wake_req(wake_req),
      .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_word(mem_word),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
   mem_model i_mem (.clock(clock), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
      .mem_word(mem_word), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock) reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock) reg_wr <= 1'b0;
   endtask
   // Data stands only in the cycle after the strobe, so look just past that edge
   task rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clock) reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock) reg_rd <= 1'b0;
      #1 chk("reg", e, reg_rdata);
   endtask
   task test_done;
      $display("tests run %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ----------------------------------------
   // Watchdog against a hang
   // ----------------------------------------
   initial begin
      #8000 err_count++;
      test_done();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      // Region at FFD00: vectors 0/1 point at sets 40 and 48
      i_mem.mem[20'hFFD00] = 8'h40;
      i_mem.mem[20'hFFD01] = 8'h48;
      i_mem.mem[20'hFFD02] = 8'h50;
      i_mem.mem[20'hFFD03] = 8'h58;
      // Set 50: high-speed, SFR source as software must use it
      {i_mem.mem[20'hFFD51], i_mem.mem[20'hFFD50]} = 16'h032C;
      {i_mem.mem[20'hFFD55], i_mem.mem[20'hFFD54]} = 16'hFF10;
      {i_mem.mem[20'hFFD57], i_mem.mem[20'hFFD56]} = 16'hE600;
      {i_mem.mem[20'hFFF11], i_mem.mem[20'hFFF10]} = 16'h2211;
      // Set 58: repeat, source is a repeat area of two units, one left
      {i_mem.mem[20'hFFD59], i_mem.mem[20'hFFD58]} = 16'h0119;
      i_mem.mem[20'hFFD5A] = 8'h02;
      {i_mem.mem[20'hFFD5D], i_mem.mem[20'hFFD5C]} = 16'hE301;
      {i_mem.mem[20'hFFD5F], i_mem.mem[20'hFFD5E]} = 16'hE400;
      i_mem.mem[20'hFE301] = 8'h77;
      {i_mem.mem[20'hFFD41], i_mem.mem[20'hFFD40]} = 16'h020C;
      {i_mem.mem[20'hFFD45], i_mem.mem[20'hFFD44]} = 16'hE100;
      {i_mem.mem[20'hFFD47], i_mem.mem[20'hFFD46]} = 16'hE200;
      i_mem.mem[20'hFE100] = 8'hA5;
      // Set 48 aims at the mirror area as destination, which is refused
      {i_mem.mem[20'hFFD49], i_mem.mem[20'hFFD48]} = 16'h010C;
      {i_mem.mem[20'hFFD4D], i_mem.mem[20'hFFD4C]} = 16'h3000;
      {i_mem.mem[20'hFFD4F], i_mem.mem[20'hFFD4E]} = 16'h3000;
      repeat (10) @(posedge clock);
      arst_n <= 1'b1;
      foreach (rows[i]) rd(rows[i][39:32], rows[i][31:0]);
      $display("reset values done");
      wr(GATE_OFS, 32'h1);
      // Second request lands while the first transfer is busy
      @(posedge clock) act_req <= 46'h1;
      @(posedge clock) act_req <= 46'h0;
      @(posedge clock) act_req <= 46'h2;
      @(posedge clock) act_req <= 46'h0;
      repeat (30) @(posedge clock);
      chk("dst byte", 8'hA5, i_mem.mem[20'hFE200]);
      chk("count", 8'h01, i_mem.mem[20'hFFD41]);
      chk("src", 16'hE101, {i_mem.mem[20'hFFD45], i_mem.mem[20'hFFD44]});
      chk("dst", 16'hE201, {i_mem.mem[20'hFFD47], i_mem.mem[20'hFFD46]});
      chk("bad cnt", 8'h01, i_mem.mem[20'hFFD49]);
      rd(STAT_OFS, 32'h2);
      wr(STAT_OFS, 32'h2);
      rd(STAT_OFS, 32'h0);
      $display("transfer and refusal done");
      // Stop mode: the request waits for the wake grant
      @(posedge clock) stop_mode <= 1'b1;
      act_req <= 46'h4;
      @(posedge clock) act_req <= 46'h0;
      repeat (3) @(posedge clock);
      #1 chk("wake", 32'h1, wake_req);
      rd(STAT_OFS, 32'h4);
      chk("held count", 8'h03, i_mem.mem[20'hFFD51]);
      @(posedge clock) wake_ack <= 1'b1;
      repeat (20) @(posedge clock);
      stop_mode <= 1'b0;
      wake_ack <= 1'b0;
      chk("wake byte", 8'h11, i_mem.mem[20'hFE600]);
      // Same source again: the cached set takes the short path
      @(posedge clock) act_req <= 46'h4;
      @(posedge clock) act_req <= 46'h0;
      repeat (10) @(posedge clock);
      chk("fast byte", 8'h22, i_mem.mem[20'hFE601]);
      chk("fast count", 8'h01, i_mem.mem[20'hFFD51]);
      chk("fast src", 16'hFF11, {i_mem.mem[20'hFFD55], i_mem.mem[20'hFFD54]});
      $display("stop mode and high-speed done");
      // Repeat set: count reaches zero, reloads and rewinds the source
      @(posedge clock) act_req <= 46'h8;
      @(posedge clock) act_req <= 46'h0;
      repeat (20) @(posedge clock);
      chk("rpt byte", 8'h77, i_mem.mem[20'hFE400]);
      chk("rpt count", 8'h02, i_mem.mem[20'hFFD59]);
      chk("rpt src", 16'hE300, {i_mem.mem[20'hFFD5D], i_mem.mem[20'hFFD5C]});
      chk("rpt dst", 16'hE401, {i_mem.mem[20'hFFD5F], i_mem.mem[20'hFFD5E]});
      $display("repeat done");
      // Reset in mid-run, then a base write while gated off is ignored
      @(posedge clock) arst_n <= 1'b0;
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      wr(CBR_OFS, 32'h12);
      rd(CBR_OFS, 32'hFD);
      rd(GATE_OFS, 32'h0);
      $display("mid-run reset done");
      test_done();
   end
endmodule
